// [hw/scd_pkg.sv]
// Function
// RULE1: chip select falling starts a new transaction
// RULE2: eight-bit command byte first, MSB first
// RULE3: input bits sampled on serial clock falling edges
// RULE4: output changes on falling edge, modes 00-10
// RULE5: output changes on rising edge in mode 11
// RULE6: chip select high abandons partial bytes
// RULE7: command byte sets 8, 16 or 24 bits
// RULE8: master keeps clock at most 25 MHz, CPOL=CPHA
// RULE9: serial clock may idle low or high
// RULE10: master holds chip select low across all bytes
// RULE11: leading bit 7 is conversion, no extra bytes
// RULE12: leading 01 is setup command with fields
// RULE13: setup mode selection adds one mode byte
// RULE14: leading 001 is averaging command, no extras
// RULE15: 0001XXXX is DAC write plus two bytes
// RULE16: leading 00001 is reset command, no extras
// RULE17: codes 3, 2, 1 are GPIO; 0 no-op
// RULE18: one shared receive path serves all sections
// RULE19: parallel results serialized onto data output
// RULE20: bipolar and temperature results in two's complement
// RULE21: arithmetic unit averages results when enabled
// RULE22: data output high impedance while chip select high
// RULE23: GPIO commands ignored on parts without GPIO
// RULE24: oldest two-byte result shifted out after select falls
// RULE25: command class from highest set bit downward
// RULE26: multi-byte commands act only when complete; setup fields act at the command byte
package scd_pkg;

	// power-up values of the writable control registers
	localparam logic [7:0] SETUP_RESET = 8'h28;
	localparam logic [7:0] AVG_RESET = 8'h00;
	localparam logic [7:0] CONV_RESET = 8'h00;
	localparam logic [7:0] RESET_CTRL_RESET = 8'h00;
	localparam logic [7:0] MODE_REG_RESET = 8'h00;

	// result path
	localparam int RESULT_WIDTH = 16;
	localparam int FIFO_DEPTH = 16;
	localparam logic [11:0] TWOS_FLIP = 12'h800;
	localparam logic [3:0] LEAD_ZEROS = 4'h0;

	// extra bytes that follow each command class
	localparam logic [1:0] EXTRA_SETUP_MODE = 2'h1;
	localparam logic [1:0] EXTRA_DAC = 2'h2;
	localparam logic [1:0] EXTRA_GPIO = 2'h2;

	// input_config codes that address the mode registers, and the external clock mode code
	localparam logic [1:0] CFG_UNIPOLAR = 2'h2;
	localparam logic [1:0] CFG_BIPOLAR = 2'h3;
	localparam logic [1:0] CLOCK_MODE_EXT = 2'h3;

	typedef enum logic [3:0] {
		CMD_NOP, CMD_GPIO_READ, CMD_GPIO_WRITE, CMD_GPIO_CONFIG, CMD_UNDEFINED,
		CMD_RESET, CMD_DAC, CMD_AVERAGE, CMD_SETUP, CMD_CONVERT
	} scd_cmd_t;

	typedef struct packed {
		logic lead;
		logic [3:0] channel;
		logic [1:0] scan_mode;
		logic temp_request;
	} scd_conv_t;

	typedef struct packed {
		logic [1:0] lead;
		logic [1:0] clock_mode;
		logic [1:0] reference_mode;
		logic [1:0] input_config;
	} scd_setup_t;

	typedef struct packed {
		logic [2:0] lead;
		logic average_enable;
		logic [1:0] average_count;
		logic [1:0] scan_repeat;
	} scd_avg_t;

	typedef struct packed {
		logic [4:0] lead;
		logic reset_request;
		logic slow_mode;
		logic bandgap_force_on;
	} scd_rst_t;

	typedef struct packed {
		logic twos_format;
		logic temperature;
		logic [11:0] code;
	} scd_result_t;

	typedef struct packed {
		scd_cmd_t op;
		logic [7:0] first;
		logic [7:0] second;
	} scd_gpio_t;

endpackage

// [hw/scd_decoder.sv]
`timescale 1ns/1ps

module scd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule // scd_fifo

module scd_decoder (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// serial pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe_n,
	// part options
	input wire logic gpio_present,
	// results from the converter
	input wire logic result_valid,
	output logic result_ready,
	input wire scd_pkg::scd_result_t result_data,
	// control registers
	output scd_pkg::scd_conv_t conversion_request_reg,
	output logic conversion_strobe_reg,
	output scd_pkg::scd_setup_t setup_control_reg,
	output scd_pkg::scd_avg_t averaging_control_reg,
	output scd_pkg::scd_rst_t reset_control_reg,
	output logic chip_reset_strobe_reg,
	output logic [7:0] unipolar_mode_reg,
	output logic [7:0] bipolar_mode_reg,
	// dac write
	output logic dac_write_strobe_reg,
	output logic [7:0] dac_select_reg,
	output logic [7:0] dac_value_reg,
	// gpio command
	output logic gpio_strobe_reg,
	output scd_pkg::scd_gpio_t gpio_command_reg
);
	localparam int RESULT_W = scd_pkg::RESULT_WIDTH;

	typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA, ST_DONE} scd_state_t;

	// two-stage synchronisers; stage one feeds stage two only
	logic cs_s1_reg, cs_s2_reg, cs_q_reg;
	logic sclk_s1_reg, sclk_s2_reg, sclk_q_reg;
	logic din_s1_reg, din_s2_reg;

	scd_state_t state_reg;
	logic [2:0] bit_cnt_reg;
	logic [6:0] rx_shift_reg;
	logic [7:0] cmd_byte_reg;
	scd_pkg::scd_cmd_t cmd_class_reg;
	logic [1:0] need_reg;
	logic [1:0] data_cnt_reg;
	logic [7:0] data0_reg;
	logic [RESULT_W-1:0] tx_shift_reg;
	logic cs_fall, sclk_fall, sclk_rise;
	logic [7:0] rx_full;
	logic byte_done, cmd_done, multi_done;
	scd_pkg::scd_cmd_t rx_class;
	logic [1:0] rx_extra;
	scd_pkg::scd_setup_t rx_setup;
	logic tx_advance;

	// fifo and averaging
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
	logic [RESULT_W-1:0] fifo_in_data, fifo_out_data;
	logic [15:0] avg_acc_reg;
	logic [3:0] avg_cnt_reg;
	logic avg_active, avg_last, res_take, res_plain;
	logic [15:0] avg_sum;
	logic [11:0] out_code;
	logic [4:0] avg_samples;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_q_reg <= 1'b1;
			sclk_s1_reg <= 1'b0;
			sclk_s2_reg <= 1'b0;
			sclk_q_reg <= 1'b0;
			din_s1_reg <= 1'b0;
			din_s2_reg <= 1'b0;
		end else begin
			cs_s1_reg <= cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_q_reg <= cs_s2_reg;
			sclk_s1_reg <= sclk;
			sclk_s2_reg <= sclk_s1_reg;
			sclk_q_reg <= sclk_s2_reg;
			din_s1_reg <= din;
			din_s2_reg <= din_s1_reg;
		end
	end

	// edges seen in either idle polarity; input works at CPOL=CPHA=0 and 1, output at 0 in clock modes 00-10 and at 1 in mode 11
	assign cs_fall = cs_q_reg && !cs_s2_reg; // RULE1
	assign sclk_fall = sclk_q_reg && !sclk_s2_reg && !cs_s2_reg; // RULE9
	assign sclk_rise = !sclk_q_reg && sclk_s2_reg && !cs_s2_reg;
	assign rx_full = {rx_shift_reg, din_s2_reg}; // RULE2
	assign byte_done = sclk_fall && (bit_cnt_reg == 3'h7) &&
		(state_reg == ST_CMD || state_reg == ST_DATA);
	assign cmd_done = byte_done && (state_reg == ST_CMD);
	assign multi_done = byte_done && (state_reg == ST_DATA) && (data_cnt_reg == need_reg - 2'h1);
	assign rx_setup = scd_pkg::scd_setup_t'(rx_full);

	// class by highest set bit, scanned from bit 7 down
	always_comb begin
		rx_class = scd_pkg::CMD_NOP; // RULE25
		if (rx_full[7]) begin
			rx_class = scd_pkg::CMD_CONVERT; // RULE11
		end else if (rx_full[6]) begin
			rx_class = scd_pkg::CMD_SETUP; // RULE12
		end else if (rx_full[5]) begin
			rx_class = scd_pkg::CMD_AVERAGE; // RULE14
		end else if (rx_full[4]) begin
			rx_class = scd_pkg::CMD_DAC; // RULE15
		end else if (rx_full[3]) begin
			rx_class = scd_pkg::CMD_RESET; // RULE16
		end else if (rx_full[2]) begin
			rx_class = scd_pkg::CMD_UNDEFINED;
		end else begin
			unique case (rx_full[1:0]) // RULE17
				2'h3: rx_class = scd_pkg::CMD_GPIO_CONFIG;
				2'h2: rx_class = scd_pkg::CMD_GPIO_WRITE;
				2'h1: rx_class = scd_pkg::CMD_GPIO_READ;
				2'h0: rx_class = scd_pkg::CMD_NOP;
			endcase
		end
	end

	// length of the whole transaction follows from the class and, for setup, the input config
	always_comb begin
		rx_extra = 2'h0; // RULE7
		if (rx_class == scd_pkg::CMD_SETUP && (rx_setup.input_config == scd_pkg::CFG_UNIPOLAR ||
				rx_setup.input_config == scd_pkg::CFG_BIPOLAR)) begin
			rx_extra = scd_pkg::EXTRA_SETUP_MODE; // RULE13
		end else if (rx_class == scd_pkg::CMD_DAC) begin
			rx_extra = scd_pkg::EXTRA_DAC; // RULE15
		end else if (rx_class == scd_pkg::CMD_GPIO_CONFIG || rx_class == scd_pkg::CMD_GPIO_WRITE ||
				rx_class == scd_pkg::CMD_GPIO_READ) begin
			rx_extra = scd_pkg::EXTRA_GPIO;
		end
	end

	// single receive path shared by converter, dac and gpio
	always_ff @(posedge ref_clk) begin
		if (reset || cs_s2_reg) begin
			state_reg <= ST_IDLE; // RULE6
			bit_cnt_reg <= 3'h0;
			rx_shift_reg <= 7'h00;
			data_cnt_reg <= 2'h0;
		end else begin
			if (sclk_fall && state_reg != ST_IDLE && state_reg != ST_DONE) begin
				bit_cnt_reg <= bit_cnt_reg + 3'h1; // RULE3
				rx_shift_reg <= rx_full[6:0];
			end
			unique case (state_reg) // RULE18
				ST_IDLE: begin
					if (cs_fall) begin
						state_reg <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (cmd_done) begin
						state_reg <= (rx_extra == 2'h0) ? ST_DONE : ST_DATA;
					end
				end
				ST_DATA: begin
					if (byte_done) begin
						data_cnt_reg <= data_cnt_reg + 2'h1;
						if (multi_done) begin
							state_reg <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					state_reg <= ST_DONE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cmd_byte_reg <= 8'h00;
			cmd_class_reg <= scd_pkg::CMD_NOP;
			need_reg <= 2'h0;
			data0_reg <= 8'h00;
		end else begin
			if (cmd_done) begin
				cmd_byte_reg <= rx_full;
				cmd_class_reg <= rx_class;
				need_reg <= rx_extra;
			end
			if (byte_done && state_reg == ST_DATA && data_cnt_reg == 2'h0) begin
				data0_reg <= rx_full;
			end
		end
	end

	// single-byte commands and the setup byte act at the command byte; extra bytes only when complete
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			conversion_request_reg <= scd_pkg::scd_conv_t'(scd_pkg::CONV_RESET);
			setup_control_reg <= scd_pkg::scd_setup_t'(scd_pkg::SETUP_RESET);
			averaging_control_reg <= scd_pkg::scd_avg_t'(scd_pkg::AVG_RESET);
			reset_control_reg <= scd_pkg::scd_rst_t'(scd_pkg::RESET_CTRL_RESET);
			conversion_strobe_reg <= 1'b0;
			chip_reset_strobe_reg <= 1'b0;
		end else begin
			conversion_strobe_reg <= 1'b0;
			chip_reset_strobe_reg <= 1'b0;
			if (cmd_done) begin
				unique case (rx_class)
					scd_pkg::CMD_CONVERT: begin
						conversion_request_reg <= scd_pkg::scd_conv_t'(rx_full); // RULE11
						conversion_strobe_reg <= 1'b1;
					end
					scd_pkg::CMD_SETUP: begin
						setup_control_reg <= rx_setup; // RULE12
					end
					scd_pkg::CMD_AVERAGE: begin
						averaging_control_reg <= scd_pkg::scd_avg_t'(rx_full); // RULE14
					end
					scd_pkg::CMD_RESET: begin
						reset_control_reg <= scd_pkg::scd_rst_t'(rx_full); // RULE16
						if (rx_full[2]) begin
							// a reset request restores the power-up conversion, setup and averaging values
							chip_reset_strobe_reg <= 1'b1;
							conversion_request_reg <= scd_pkg::scd_conv_t'(scd_pkg::CONV_RESET);
							setup_control_reg <= scd_pkg::scd_setup_t'(scd_pkg::SETUP_RESET);
							averaging_control_reg <= scd_pkg::scd_avg_t'(scd_pkg::AVG_RESET);
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			unipolar_mode_reg <= scd_pkg::MODE_REG_RESET;
			bipolar_mode_reg <= scd_pkg::MODE_REG_RESET;
			dac_write_strobe_reg <= 1'b0;
			dac_select_reg <= 8'h00;
			dac_value_reg <= 8'h00;
			gpio_strobe_reg <= 1'b0;
			gpio_command_reg <= '0;
		end else begin
			dac_write_strobe_reg <= 1'b0;
			gpio_strobe_reg <= 1'b0;
			if (multi_done) begin // RULE26
				unique case (cmd_class_reg)
					scd_pkg::CMD_SETUP: begin
						if (cmd_byte_reg[1:0] == scd_pkg::CFG_BIPOLAR) begin
							bipolar_mode_reg <= rx_full; // RULE13
						end else begin
							unipolar_mode_reg <= rx_full;
						end
					end
					scd_pkg::CMD_DAC: begin
						dac_select_reg <= data0_reg; // RULE15
						dac_value_reg <= rx_full;
						dac_write_strobe_reg <= 1'b1;
					end
					scd_pkg::CMD_GPIO_CONFIG, scd_pkg::CMD_GPIO_WRITE,
					scd_pkg::CMD_GPIO_READ: begin
						if (gpio_present) begin // RULE23
							gpio_command_reg <= '{op: cmd_class_reg, first: data0_reg,
								second: rx_full};
							gpio_strobe_reg <= 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// averaging unit; temperature results and clock mode 11 bypass it
	assign avg_active = averaging_control_reg.average_enable &&
		(setup_control_reg.clock_mode != scd_pkg::CLOCK_MODE_EXT);
	assign avg_samples = 5'h1 << (3'(averaging_control_reg.average_count) + 3'h1); // 5 bits: 16
	assign avg_last = (avg_cnt_reg == 4'(avg_samples - 5'h1));
	assign res_plain = !avg_active || result_data.temperature;
	assign avg_sum = avg_acc_reg + {4'h0, result_data.code};
	assign fifo_in_valid = result_valid && (res_plain || avg_last);
	assign result_ready = fifo_in_ready || (!res_plain && !avg_last);
	assign res_take = result_valid && result_ready;

	always_comb begin
		out_code = result_data.code;
		if (!res_plain) begin
			out_code = 12'(avg_sum >> (3'(averaging_control_reg.average_count) + 3'h1)); // RULE21
		end
		if (result_data.twos_format) begin
			out_code = out_code ^ scd_pkg::TWOS_FLIP; // RULE20
		end
		fifo_in_data = {scd_pkg::LEAD_ZEROS, out_code};
	end

	always_ff @(posedge ref_clk) begin
		if (reset || chip_reset_strobe_reg) begin
			avg_acc_reg <= 16'h0000;
			avg_cnt_reg <= 4'h0;
		end else if (res_take && !res_plain) begin
			avg_acc_reg <= avg_last ? 16'h0000 : avg_sum; // RULE21
			avg_cnt_reg <= avg_last ? 4'h0 : avg_cnt_reg + 4'h1;
		end
	end

	// result store; a full store stalls the converter rather than overwrite
	scd_fifo #(
		.WIDTH(RESULT_W),
		.DEPTH(scd_pkg::FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.reset(reset),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(cs_fall),
		.out_data(fifo_out_data)
	);

	// output shifter; bits past the first two bytes read as zero
	assign tx_advance = (setup_control_reg.clock_mode == scd_pkg::CLOCK_MODE_EXT) ?
		sclk_rise : sclk_fall; // RULE5

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_shift_reg <= '0;
		end else if (cs_fall) begin
			tx_shift_reg <= fifo_out_valid ? fifo_out_data : '0; // RULE24
		end else if (tx_advance) begin
			tx_shift_reg <= {tx_shift_reg[RESULT_W-2:0], 1'b0}; // RULE4 RULE19
		end
	end

	assign dout = tx_shift_reg[RESULT_W-1];
	assign dout_oe_n = cs_s2_reg; // RULE22

endmodule // scd_decoder

// [testbench/scd_decoder_sva.sv]
`timescale 1ns/1ps

module scd_decoder_sva (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// serial pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic dout,
	input wire logic dout_oe_n,
	// part options
	input wire logic gpio_present,
	// control registers
	input wire scd_pkg::scd_conv_t conversion_request_reg,
	input wire logic conversion_strobe_reg,
	input wire scd_pkg::scd_setup_t setup_control_reg,
	input wire scd_pkg::scd_rst_t reset_control_reg,
	input wire logic chip_reset_strobe_reg,
	input wire logic dac_write_strobe_reg,
	input wire logic gpio_strobe_reg,
	input wire scd_pkg::scd_gpio_t gpio_command_reg
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_sclk_quiet;
		$stable(sclk) [*8];
	endsequence
	sequence s_cs_high;
		cs_n [*5];
	endsequence
	sequence s_cs_low;
		!cs_n [*5];
	endsequence
	// long enough that a late strobe of the last frame has landed
	sequence s_cs_idle;
		cs_n [*8];
	endsequence

	a_oe_released: assert property (s_cs_high |-> dout_oe_n)
		else $error("data output driven while deselected");
	a_oe_selected: assert property (s_cs_low |-> !dout_oe_n)
		else $error("data output not driven after select");
	a_dout_moves_edge: assert property (
		s_sclk_quiet ##0 (!dout_oe_n && !$past(dout_oe_n, 2)) |-> $stable(dout))
		else $error("data output moved without a serial clock edge");
	a_conv_lead: assert property (
		conversion_strobe_reg |-> conversion_request_reg.lead ##1 !conversion_strobe_reg)
		else $error("bad conversion strobe");
	a_dac_pulse: assert property ($rose(dac_write_strobe_reg) |=> $fell(dac_write_strobe_reg))
		else $error("dac strobe not a single pulse");
	a_act_inside: assert property (
		(conversion_strobe_reg || dac_write_strobe_reg || gpio_strobe_reg) |-> !dout_oe_n)
		else $error("command acted outside a frame");
	a_idle_no_act: assert property (
		s_cs_idle |-> !(conversion_strobe_reg || dac_write_strobe_reg || gpio_strobe_reg))
		else $error("command acted while deselected");
	a_gpio_strap: assert property (!gpio_present |-> !gpio_strobe_reg)
		else $error("gpio command acted without gpio pins");
	a_gpio_ops: assert property (gpio_strobe_reg |-> gpio_command_reg.op inside
		{scd_pkg::CMD_GPIO_READ, scd_pkg::CMD_GPIO_WRITE, scd_pkg::CMD_GPIO_CONFIG})
		else $error("gpio strobe with foreign opcode");
	a_reset_restore: assert property (chip_reset_strobe_reg |->
		reset_control_reg.reset_request ##[0:2] setup_control_reg == scd_pkg::SETUP_RESET)
		else $error("reset command did not restore setup");
endmodule // scd_decoder_sva

bind scd_decoder scd_decoder_sva u_scd_decoder_sva (.ref_clk, .reset, .cs_n, .sclk, .dout,
	.dout_oe_n, .gpio_present, .conversion_request_reg, .conversion_strobe_reg,
	.setup_control_reg, .reset_control_reg, .chip_reset_strobe_reg, .dac_write_strobe_reg,
	.gpio_strobe_reg, .gpio_command_reg);

// [testbench/scd_master_model.sv]
`timescale 1ns/1ps

module scd_master_model (
	// clock
	input wire logic ref_clk,
	// serial pins
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout
);
	localparam int HALF = 10;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// 80 ns phases; clock parks at its idle level between frames
	task automatic xfer(input logic [23:0] data, input int nbits, input logic idle_hi,
		output logic [23:0] rx);
		rx = 24'h000000;
		wait_clk(1);
		sclk <= idle_hi;
		wait_clk(4);
		cs_n <= 1'b0;
		wait_clk(6);
		// data moves mid-phase, clear of the sampling fall; dout read mid-phase after the
		// first edge, so an advance on the wrong edge shows up as a skipped bit
		for (int i = 0; i < nbits; i++) begin
			wait_clk(HALF / 2);
			din <= data[23 - i];
			wait_clk(HALF / 2);
			sclk <= !idle_hi;
			wait_clk(HALF / 2);
			rx = {rx[22:0], dout};
			wait_clk(HALF / 2);
			sclk <= idle_hi;
		end
		wait_clk(HALF);
		cs_n <= 1'b1;
		// undriven data line must not look like a held bit
		din <= !din;
		wait_clk(6);
	endtask
endmodule // scd_master_model

// [testbench/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic gpio_present = 1'b1;
	logic result_valid = 1'b0;
	scd_pkg::scd_result_t result_data = '0;
	logic cs_n, sclk, din, dout, dout_oe_n, result_ready, conversion_strobe_reg;
	logic chip_reset_strobe_reg, dac_write_strobe_reg, gpio_strobe_reg;
	scd_pkg::scd_conv_t conversion_request_reg;
	scd_pkg::scd_setup_t setup_control_reg;
	scd_pkg::scd_avg_t averaging_control_reg;
	scd_pkg::scd_rst_t reset_control_reg;
	scd_pkg::scd_gpio_t gpio_command_reg;
	logic [7:0] unipolar_mode_reg, bipolar_mode_reg, dac_select_reg, dac_value_reg;
	logic [7:0] b, m, p, q, exp_u, exp_b;
	logic [23:0] rx;
	logic [1:0] k;
	logic [15:0] avg_total;
	scd_pkg::scd_result_t r;
	logic [15:0] words[$];
	int bad_count = 0;
	int samples_checked = 0;
	int dac_hits = 0;
	int gpio_hits = 0;

	always #4 ref_clk = ~ref_clk;

	scd_decoder u_scd_decoder (.ref_clk, .reset, .cs_n, .sclk, .din, .dout, .dout_oe_n,
		.gpio_present, .result_valid, .result_ready, .result_data, .conversion_request_reg,
		.conversion_strobe_reg, .setup_control_reg, .averaging_control_reg,
		.reset_control_reg, .chip_reset_strobe_reg, .unipolar_mode_reg, .bipolar_mode_reg,
		.dac_write_strobe_reg, .dac_select_reg, .dac_value_reg, .gpio_strobe_reg,
		.gpio_command_reg);
	scd_master_model u_scd_master_model (.ref_clk, .cs_n, .sclk, .din, .dout);

	always @(posedge ref_clk) begin
		if (dac_write_strobe_reg === 1'b1)
			dac_hits++;
		if (gpio_strobe_reg === 1'b1)
			gpio_hits++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic send(input logic [23:0] data, input int nbits);
		u_scd_master_model.xfer(data, nbits, 1'b0, rx);
	endtask

	function automatic logic [15:0] word_of(input scd_pkg::scd_result_t r);
		return {4'h0, r.code ^ (r.twos_format ? scd_pkg::TWOS_FLIP : 12'h000)};
	endfunction

	// count code c averages 2^(c+1) samples
	function automatic logic [15:0] avg_word(input logic [15:0] total, input logic [1:0] c);
		return 16'(int'(total) >> (int'(c) + 1));
	endfunction

	// ready is looked at half a cycle early: it cannot change before the taking edge
	task automatic push(input scd_pkg::scd_result_t r);
		@(posedge ref_clk);
		result_valid <= 1'b1;
		result_data <= r;
		for (int i = 0; i < 40; i++) begin
			@(negedge ref_clk);
			if (result_ready === 1'b1) begin
				@(posedge ref_clk);
				result_valid <= 1'b0;
				words.push_back(word_of(r));
				return;
			end
		end
		bad_count++;
		print_verdict();
	endtask

	initial begin
		void'($urandom(58527));
		exp_u = 8'h00;
		exp_b = 8'h00;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check(setup_control_reg, scd_pkg::SETUP_RESET);
		check(dout_oe_n, 1'b1);
		for (int i = 0; i < 16; i++)
			push(14'($urandom));
		@(posedge ref_clk);
		result_valid <= 1'b1;
		repeat (3) @(negedge ref_clk);
		check(result_ready, 1'b0);
		@(posedge ref_clk);
		result_valid <= 1'b0;
		for (int i = 0; i < 17; i++) begin
			send(24'h000000, 16);
			check(rx[15:0], i < 16 ? words.pop_front() : 16'h0000);
		end
		b = {1'b1, 7'($urandom)};
		send({b, 16'h0000}, 8);
		check(conversion_request_reg, b);
		// every clock mode and input config; extra byte sent even where it must be ignored
		for (int i = 0; i < 4; i++) begin
			b = {2'b01, 2'(i), 2'($urandom), 2'(i)};
			m = 8'($urandom);
			send({b, m, 8'h00}, 16);
			if (i == 2)
				exp_u = m;
			if (i == 3)
				exp_b = m;
			check(setup_control_reg, b);
			check({unipolar_mode_reg, bipolar_mode_reg}, {exp_u, exp_b});
		end
		// one result read back in clock mode 11 with the clock idling high
		push(14'($urandom));
		b = {1'b1, 7'($urandom)};
		u_scd_master_model.xfer({b, 16'h0000}, 16, 1'b1, rx);
		check(conversion_request_reg, b);
		check(rx[15:0], words.pop_front());
		b = {3'b001, 5'($urandom)};
		send({b, 16'h0000}, 8);
		check(averaging_control_reg, b);
		b = {4'h1, 4'($urandom)};
		p = 8'($urandom);
		q = 8'($urandom);
		send({b, p, q}, 24);
		check({dac_select_reg, dac_value_reg, 8'(dac_hits)}, {p, q, 8'h01});
		send({b, ~p, ~q}, 20);
		check({dac_select_reg, dac_value_reg, 8'(dac_hits)}, {p, q, 8'h01});
		b = {5'b00001, 1'b1, 2'($urandom)};
		send({b, 16'h0000}, 8);
		check(reset_control_reg, b);
		check({setup_control_reg, averaging_control_reg},
			{scd_pkg::SETUP_RESET, scd_pkg::AVG_RESET});
		for (int i = 1; i < 4; i++) begin
			p = 8'($urandom);
			q = 8'($urandom);
			send({8'(i), p, q}, 24);
			check(gpio_command_reg, {4'(i), p, q});
		end
		// reserved codes and no-op must act on nothing
		send({6'h01, 2'($urandom), p, q}, 24);
		send({8'h00, ~p, ~q}, 24);
		check({8'(dac_hits), 8'(gpio_hits), setup_control_reg},
			{8'h01, 8'h03, scd_pkg::SETUP_RESET});
		gpio_present <= 1'b0;
		send({8'h02, ~p, q}, 24);
		check({gpio_command_reg, 8'(gpio_hits)}, {4'h3, p, q, 8'h03});
		// averaging: the sixteen-sample corner first, then a random count
		for (int j = 0; j < 2; j++) begin
			k = (j == 0) ? 2'h3 : 2'($urandom);
			send({3'b001, 1'b1, k, 2'($urandom), 16'h0000}, 8);
			avg_total = 16'h0000;
			for (int n = 0; n < (2 << k); n++) begin
				r = {2'b00, 12'($urandom)};
				avg_total = avg_total + {4'h0, r.code};
				push(r);
			end
			send(24'h000000, 16);
			check(rx[15:0], avg_word(avg_total, k));
		end
		words.delete();
		print_verdict();
	end
endmodule // tb_top
